// ---- rtl/bcfgl_pkg.sv ----
package bcfgl_pkg;

    // byte offsets of the header fields held here
    localparam logic [7:0] OFS_MAKER_ID  = 8'h00;
    localparam logic [7:0] OFS_PART_ID   = 8'h02;
    localparam logic [7:0] OFS_CMD       = 8'h04;

    // dword index as carried on address bits 7:2
    localparam logic [5:0] DW_IDENT      = OFS_MAKER_ID[7:2];
    localparam logic [5:0] DW_CMD        = OFS_CMD[7:2];

    // field positions inside the identification dword
    localparam int         MAKER_LSB     = 0;
    localparam int         PART_LSB      = 16;

    // command register bit positions
    localparam int         CMD_IO_BIT    = 0;
    localparam int         CMD_MEM_BIT   = 1;
    localparam int         CMD_MST_BIT   = 2;
    localparam int         CMD_SPC_BIT   = 3;
    localparam int         CMD_MWI_BIT   = 4;
    localparam int         CMD_RW_W      = 3;

    // reset value of the writable command bits
    localparam logic [2:0] CMD_RST       = 3'h0;
    localparam logic [31:0] RD_ZERO      = 32'h0000_0000;

endpackage

// ---- rtl/bcfgl_lane.sv ----
`timescale 1ns/1ns

// per-byte lane selection from the active-low byte enables
module bcfgl_lane
    import bcfgl_pkg::*;
(
    input  wire logic [3:0]  cbe_n,     // byte enables, active low
    input  wire logic [31:0] raw,       // full dword contents
    output wire logic [31:0] masked,    // only selected bytes, rest zero
    output wire logic [3:0]  sel        // lane selected, active high
);

    // one lane per byte; an unselected lane returns zero
    for (genvar b = 0; b < 4; b++)
    begin : g_lane
        assign sel[b]            = ~cbe_n[b];
        assign masked[8*b +: 8]  = cbe_n[b] ? 8'h00 : raw[8*b +: 8];
    end

endmodule

// ---- rtl/bcfgl_top.sv ----
// Summary of operation
// - low byte enable selects each byte field
// - reserved fields ignore writes, read zero
// - maker code hardwired in bits 15:0
// - part code hardwired in bits 31:16
// - bit 0 gates primary I/O claim
// - bit 1 gates primary memory claim
// - bit 2 gates mastering and secondary claims
// - configuration forwarding ignores master enable
// - bit 3 reads zero, special cycles ignored
// - bit 4 reads zero, MWI only forwarded
// - Type 0 access, dword on address 7:2
`timescale 1ns/1ns

module bcfgl_top
    import bcfgl_pkg::*;
#(
    parameter logic [15:0] MAKER_ID = 16'h5A5A,   // arbitrary value
    parameter logic [15:0] PART_ID  = 16'h0C3C    // arbitrary value
)
(
    input  wire logic        clk,           // primary bus clock
    input  wire logic        sys_rst,       // async reset, active high
    input  wire logic        cfg_req,       // config data phase, one cycle
    input  wire logic        cfg_type0,     // access is Type 0
    input  wire logic        cfg_write,     // 1 write, 0 read
    input  wire logic [5:0]  cfg_dword,     // dword index, address 7:2
    input  wire logic [3:0]  cfg_cbe_n,     // byte enables, active low
    input  wire logic [31:0] cfg_wdata,     // write data
    input  wire logic        pri_io_hit,    // primary I/O decode hit
    input  wire logic        pri_mem_hit,   // primary memory decode hit
    input  wire logic        sec_io_hit,    // secondary I/O decode hit
    input  wire logic        sec_mem_hit,   // secondary memory decode hit
    input  wire logic        sec_cfg_fwd,   // config cycle to forward
    input  wire logic        fwd_mwi,       // forwarding another master's MWI
    output logic             cfg_ack,       // access taken, one cycle
    output logic      [31:0] cfg_rdata,     // read data, held
    output logic             pri_io_claim,  // claim primary I/O
    output logic             pri_mem_claim, // claim primary memory
    output logic             sec_io_claim,  // claim secondary I/O
    output logic             sec_mem_claim, // claim secondary memory
    output logic             pri_init_ok,   // may master on primary
    output logic             cfg_fwd_go,    // forward config cycle
    output logic             mwi_issue,     // issue MWI on primary
    output logic      [2:0]  cmd_en         // io, mem, master enables
);

    logic        take;
    logic        hit_ident;
    logic        hit_cmd;
    logic [31:0] raw;
    logic [31:0] masked;
    logic [3:0]  sel;
    logic        next_ack;
    logic [31:0] next_rdata;
    logic [2:0]  next_cmd;
    logic        next_io_claim;
    logic        next_mem_claim;
    logic        next_sec_io;
    logic        next_sec_mem;
    logic        next_init_ok;
    logic        next_fwd_go;
    logic        next_mwi;

    bcfgl_lane u_lane (
        .cbe_n  (cfg_cbe_n),
        .raw    (raw),
        .masked (masked),
        .sel    (sel)
    );

    // only Type 0 accesses belong to this header; others are left alone
    always_comb
    begin
        take      = cfg_req & cfg_type0;
        hit_ident = (cfg_dword == DW_IDENT);
        hit_cmd   = (cfg_dword == DW_CMD);
        raw       = RD_ZERO;
        if (hit_ident)
        begin
            raw[MAKER_LSB +: 16] = MAKER_ID;
            raw[PART_LSB +: 16]  = PART_ID;
        end
        else if (hit_cmd)
        begin
            raw[CMD_RW_W-1:0] = cmd_en;
        end
    end

    // register access: ack every taken access, writes complete silently
    always_comb
    begin
        next_ack   = take;
        next_rdata = cfg_rdata;
        next_cmd   = cmd_en;
        if (take && !cfg_write)
        begin
            next_rdata = masked;
        end
        if (take && cfg_write && hit_cmd && sel[0])
        begin
            next_cmd = cfg_wdata[CMD_RW_W-1:0];
        end
    end

    // transaction gating; registered so claims follow a stable enable
    always_comb
    begin
        next_io_claim  = pri_io_hit & cmd_en[CMD_IO_BIT];
        next_mem_claim = pri_mem_hit & cmd_en[CMD_MEM_BIT];
        next_sec_io    = sec_io_hit & cmd_en[CMD_MST_BIT];
        next_sec_mem   = sec_mem_hit & cmd_en[CMD_MST_BIT];
        next_init_ok   = cmd_en[CMD_MST_BIT];
        next_fwd_go    = sec_cfg_fwd;
        next_mwi       = fwd_mwi;
    end

    // special cycles have no input here at all, so none is ever claimed
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cfg_ack       <= 1'h0;
            cfg_rdata     <= RD_ZERO;
            cmd_en        <= CMD_RST;
            pri_io_claim  <= 1'h0;
            pri_mem_claim <= 1'h0;
            sec_io_claim  <= 1'h0;
            sec_mem_claim <= 1'h0;
            pri_init_ok   <= 1'h0;
            cfg_fwd_go    <= 1'h0;
            mwi_issue     <= 1'h0;
        end
        else
        begin
            cfg_ack       <= next_ack;
            cfg_rdata     <= next_rdata;
            cmd_en        <= next_cmd;
            pri_io_claim  <= next_io_claim;
            pri_mem_claim <= next_mem_claim;
            sec_io_claim  <= next_sec_io;
            sec_mem_claim <= next_sec_mem;
            pri_init_ok   <= next_init_ok;
            cfg_fwd_go    <= next_fwd_go;
            mwi_issue     <= next_mwi;
        end
    end

    // checks on the header behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_ack_type0:
        assert property (cfg_req && cfg_type0 |=> cfg_ack)
        else $error("type 0 access not acknowledged");

    a_ignore_type1:
        assert property (!(cfg_req && cfg_type0) |=> !cfg_ack)
        else $error("ack without a type 0 access");

    a_maker_read:
        assert property (cfg_req && cfg_type0 && !cfg_write && cfg_dword == DW_IDENT
                         && cfg_cbe_n[1:0] == 2'h0 |=> cfg_rdata[15:0] == MAKER_ID)
        else $error("maker code read wrong");

    a_part_read:
        assert property (cfg_req && cfg_type0 && !cfg_write && cfg_dword == DW_IDENT
                         && cfg_cbe_n[3:2] == 2'h0 |=> cfg_rdata[31:16] == PART_ID)
        else $error("part code read wrong");

    a_lane_zero:
        assert property (cfg_req && cfg_type0 && !cfg_write && cfg_cbe_n[0]
                         |=> cfg_rdata[7:0] == 8'h00)
        else $error("unselected byte not zero");

    a_reserved_zero:
        assert property (cfg_req && cfg_type0 && !cfg_write && cfg_dword > DW_CMD
                         |=> cfg_rdata == RD_ZERO)
        else $error("reserved dword read nonzero");

    a_cmd_hiwired:
        assert property (cfg_req && cfg_type0 && !cfg_write && cfg_dword == DW_CMD
                         |=> cfg_rdata[31:3] == 29'h0000_0000)
        else $error("hardwired command bits nonzero");

    a_cmd_write:
        assert property (cfg_req && cfg_type0 && cfg_write && cfg_dword == DW_CMD
                         && !cfg_cbe_n[0] |=> cmd_en == $past(cfg_wdata[2:0]))
        else $error("command write not stored");

    a_cmd_skip:
        assert property (!(cfg_req && cfg_type0 && cfg_write && cfg_dword == DW_CMD
                         && !cfg_cbe_n[0]) |=> $stable(cmd_en))
        else $error("command changed without selected write");

    a_io_gate:
        assert property (pri_io_claim |-> $past(pri_io_hit) && $past(cmd_en[0]))
        else $error("I/O claimed while disabled");

    a_mem_gate:
        assert property (pri_mem_claim |-> $past(pri_mem_hit) && $past(cmd_en[1]))
        else $error("memory claimed while disabled");

    a_master_gate:
        assert property ((sec_io_claim || sec_mem_claim || pri_init_ok)
                         |-> $past(cmd_en[2]))
        else $error("master activity while disabled");

    a_cfg_forward:
        assert property (sec_cfg_fwd |=> cfg_fwd_go)
        else $error("config forward blocked");

    a_mwi_only_fwd:
        assert property (mwi_issue |-> $past(fwd_mwi))
        else $error("MWI issued without forwarding");

    c_ident_read:
        cover property (cfg_req && cfg_type0 && !cfg_write && cfg_dword == DW_IDENT
                        && cfg_cbe_n == 4'h0 ##1 cfg_ack);
    c_cmd_enable:
        cover property (cfg_req && cfg_type0 && cfg_write && cfg_dword == DW_CMD
                        ##1 cmd_en == 3'h7);
    c_io_claim:
        cover property (pri_io_claim);
    c_fwd_no_master:
        cover property (cfg_fwd_go && !cmd_en[2]);

endmodule

// ---- tb/bcfgl_host.sv ----
`timescale 1ns/1ns

// primary-bus configuration initiator driving the register port
module bcfgl_host
(
    input  wire logic        clk,       // primary clock
    input  wire logic        cfg_ack,   // access taken
    input  wire logic [31:0] cfg_rdata, // read data
    output logic             cfg_req,   // data phase strobe
    output logic             cfg_type0, // type 0 access
    output logic             cfg_write, // write when high
    output logic      [5:0]  cfg_dword, // dword index
    output logic      [3:0]  cfg_cbe_n, // byte enables, active low
    output logic      [31:0] cfg_wdata  // write data
);
    // idle lines from time zero
    initial
    begin
        cfg_req = 1'h0;
        cfg_type0 = 1'h0;
        cfg_write = 1'h0;
        cfg_dword = 6'h00;
        cfg_cbe_n = 4'hF;
        cfg_wdata = 32'h0000_0000;
    end

    // one access; strobe is a single-cycle pulse, answer seen one cycle on
    task automatic access(input logic wr, input logic t0, input logic [5:0] dw,
                          input logic [3:0] be_n, input logic [31:0] wd,
                          output logic ack, output logic [31:0] rd);
        @(negedge clk);
        cfg_req = 1'h1;
        cfg_type0 = t0;
        cfg_write = wr;
        cfg_dword = dw;
        cfg_cbe_n = be_n;
        cfg_wdata = wd;
        @(negedge clk);
        ack = cfg_ack;
        rd = cfg_rdata;
        cfg_req = 1'h0;
        // released lines must not look like the last value
        cfg_wdata = ~wd;
        cfg_dword = ~dw;
        cfg_cbe_n = ~be_n;
    endtask
endmodule

// ---- tb/bcfgl_top_tb.sv ----
`timescale 1ns/1ns

module bcfgl_top_tb
    import bcfgl_pkg::*;
;
    localparam logic [15:0] MK = 16'h1234; // arbitrary value
    localparam logic [15:0] PT = 16'h4321; // arbitrary value
    logic        clk;
    logic        sys_rst;
    logic        cfg_req;
    logic        cfg_type0;
    logic        cfg_write;
    logic [5:0]  cfg_dword;
    logic [3:0]  cfg_cbe_n;
    logic [31:0] cfg_wdata;
    logic        cfg_ack;
    logic [31:0] cfg_rdata;
    logic [5:0]  side;
    wire  [5:0]  outs;
    logic        pri_init_ok;
    logic [2:0]  cmd_en;
    logic        a;
    logic [31:0] r;
    int          error_cnt = 0;
    int          samples_checked = 0;

    bcfgl_top #(.MAKER_ID(MK), .PART_ID(PT)) u_bcfgl_top (
        .clk(clk), .sys_rst(sys_rst), .cfg_req(cfg_req), .cfg_type0(cfg_type0),
        .cfg_write(cfg_write), .cfg_dword(cfg_dword), .cfg_cbe_n(cfg_cbe_n),
        .cfg_wdata(cfg_wdata), .pri_io_hit(side[0]), .pri_mem_hit(side[1]),
        .sec_io_hit(side[2]), .sec_mem_hit(side[3]), .sec_cfg_fwd(side[4]),
        .fwd_mwi(side[5]), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
        .pri_io_claim(outs[0]), .pri_mem_claim(outs[1]), .sec_io_claim(outs[2]),
        .sec_mem_claim(outs[3]), .pri_init_ok(pri_init_ok), .cfg_fwd_go(outs[4]),
        .mwi_issue(outs[5]), .cmd_en(cmd_en));

    bcfgl_host u_bcfgl_host (
        .clk(clk), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .cfg_req(cfg_req),
        .cfg_type0(cfg_type0), .cfg_write(cfg_write), .cfg_dword(cfg_dword),
        .cfg_cbe_n(cfg_cbe_n), .cfg_wdata(cfg_wdata));

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic acc(input logic wr, input logic t0, input logic [5:0] dw,
                       input logic [3:0] be, input logic [31:0] wd);
        u_bcfgl_host.access(wr, t0, dw, be, wd, a, r);
    endtask

    task automatic t_ident;
        acc(0, 1, DW_IDENT, 4'h0, 32'h0);
        check("ident ack", {31'h0, a}, 32'h1);
        check("ident all", r, {PT, MK});
        acc(0, 1, DW_IDENT, 4'h3, 32'h0);
        check("part only", r, {PT, 16'h0000});
        acc(0, 1, DW_IDENT, 4'hC, 32'h0);
        check("maker only", r, {16'h0000, MK});
        acc(1, 1, DW_IDENT, 4'h0, 32'hFFFF_FFFF);
        check("ro write ack", {31'h0, a}, 32'h1);
        acc(0, 1, DW_IDENT, 4'h0, 32'h0);
        check("ident kept", r, {PT, MK});
        $display("test ident done");
    endtask

    task automatic t_cmd;
        check("cmd reset", {29'h0, cmd_en}, 32'h0);
        acc(1, 1, DW_CMD, 4'h0, 32'hFFFF_FFFF);
        check("cmd set", {29'h0, cmd_en}, 32'h7);
        acc(0, 1, DW_CMD, 4'h0, 32'h0);
        check("cmd read", r, 32'h7);
        acc(1, 1, DW_CMD, 4'h1, 32'h0);
        check("lane0 off", {29'h0, cmd_en}, 32'h7);
        acc(1, 1, DW_CMD, 4'hE, 32'h5);
        check("lane0 on", {29'h0, cmd_en}, 32'h5);
        acc(1, 0, DW_CMD, 4'h0, 32'h0);
        check("type1 ack", {31'h0, a}, 32'h0);
        check("type1 kept", {29'h0, cmd_en}, 32'h5);
        $display("test cmd done");
    endtask

    task automatic t_resv;
        logic [5:0] dws [3] = '{6'h02, 6'h03, 6'h3F};
        foreach (dws[i])
        begin
            acc(1, 1, dws[i], 4'h0, 32'hFFFF_FFFF);
            check("resv ack", {31'h0, a}, 32'h1);
            acc(0, 1, dws[i], 4'h0, 32'h0);
            check("resv read", r, 32'h0);
        end
        $display("test reserved done");
    endtask

    task automatic t_gate;
        for (int v = 0; v < 8; v++)
        begin
            acc(1, 1, DW_CMD, 4'hE, 32'(v));
            check("idle outs", {26'h0, outs}, 32'h0);
            side = 6'h3F;
            @(negedge clk);
            side = 6'h00;
            check("claims", {26'h0, outs}, {26'h0, 2'h3, v[2], v[2], v[1], v[0]});
            check("init ok", {31'h0, pri_init_ok}, {31'h0, v[2]});
        end
        $display("test gating done");
    endtask

    // mid-run reset after all enables were set by the gating test
    task automatic t_rst;
        sys_rst = 1'h1;
        repeat (2) @(negedge clk);
        sys_rst = 1'h0;
        check("rst cmd", {29'h0, cmd_en}, 32'h0);
        check("rst rdata", cfg_rdata, 32'h0);
        check("rst outs", {25'h0, pri_init_ok, outs}, 32'h0);
        acc(0, 1, DW_CMD, 4'h0, 32'h0);
        check("rst cmd read", r, 32'h0);
        $display("test reset done");
    endtask

    // free-running primary clock
    initial
    begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    // hang guard, 3000 cycles, far beyond the roughly 70 cycles the tests take
    initial
    begin
        #(8 * 3000);
        error_cnt++;
        $display("watchdog expired");
        complete_run;
    end

    // main sequence
    initial
    begin
        sys_rst = 1'h1;
        side = 6'h00;
        repeat (8) @(negedge clk);
        sys_rst = 1'h0;
        t_cmd;
        t_ident;
        t_resv;
        t_gate;
        t_rst;
        complete_run;
    end
endmodule
